// ==== sct_apb_master.sv ====
// partner: apb master applying test vectors to the test control block
`timescale 1ns/1ps
`default_nettype none

module sct_apb_master
(
   input  wire logic                       clk,       // clock
   input  wire logic [sct_pkg::DATA_W-1:0] prdata_q,  // read data
   output var  sct_pkg::sct_apb_req_t      apb_req    // request fields
);
   initial apb_req = '0;

   // released address and data show the inverse, never a stale copy
   task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] wd,
                       output logic [31:0] rd);
      @(posedge clk);
      apb_req <= '{sel: 1'b1, enable: 1'b0, write: w, addr: a, wdata: wd};
      @(posedge clk);
      apb_req.enable <= 1'b1;
      @(posedge clk);
      rd = prdata_q;
      apb_req <= '{sel: 1'b0, enable: 1'b0, write: w, addr: ~a, wdata: ~wd};
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] unused;
      xfer(1'b1, a, d, unused);
   endtask

   task automatic rd(input logic [7:0] a, output logic [31:0] d);
      xfer(1'b0, a, 32'h0000_0000, d);
   endtask
endmodule // sct_apb_master

`default_nettype wire

// ==== sct_nibble_counter.sv ====
// file: one 16-bit up counter with a nibble-parallel test mode
`timescale 1ns/1ps
`default_nettype none

module sct_nibble_counter
(
   input  wire logic                      clk,        // 125 MHz clock
   input  wire logic                      rst,        // async reset, active high
   input  wire logic                      ce,         // global clock enable
   input  wire logic                      step,       // count this cycle
   input  wire logic                      clear,      // synchronous clear
   input  wire logic                      nibble,     // nibble mode select
   output logic      [sct_pkg::CNT_W-1:0] count_q     // counter value
);

   logic [sct_pkg::CNT_W-1:0] nib_inc;
   logic [sct_pkg::CNT_W-1:0] count_d;

   // ====================================================================
   // per-nibble incrementers; each nibble wraps on its own
   genvar g;
   generate
      for (g = 0; g < sct_pkg::CNT_W / sct_pkg::NIB_W; g++)
      begin : g_nib
         assign nib_inc[g*sct_pkg::NIB_W +: sct_pkg::NIB_W] =
            count_q[g*sct_pkg::NIB_W +: sct_pkg::NIB_W] + sct_pkg::NIB_ONE;
      end
   endgenerate

   always_comb
   begin
      count_d = count_q;
      if (clear)
      begin
         count_d = sct_pkg::CNT_ZERO;
      end
      else if (step)
      begin
         // in nibble mode all four nibbles step together: 0000, 1111 ... ffff, 0000
         count_d = nibble ? nib_inc : count_q + sct_pkg::CNT_ONE;
      end
   end

   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         count_q <= sct_pkg::CNT_ZERO;
      end
      else if (ce)
      begin
         count_q <= count_d;
      end
   end

endmodule // sct_nibble_counter

`default_nettype wire

// ==== sct_pkg.sv ====
// package: register map, field layout and carrier types of the card interface test control
package sct_pkg;

   // ====================================================================
   // bus widths
   localparam int ADDR_W = 8;
   localparam int DATA_W = 32;
   localparam int CNT_W  = 16;
   localparam int NIB_W  = 4;
   localparam int NUM_CNT = 6;
   localparam int NUM_PIN = 4;

   // ====================================================================
   // register offsets (byte addresses)
   localparam logic [ADDR_W-1:0] OFF_TEST_CONTROL   = 8'h80;
   localparam logic [ADDR_W-1:0] OFF_NIBBLE_MODE    = 8'h84;
   localparam logic [ADDR_W-1:0] OFF_INPUT_STIMULUS = 8'h88;
   localparam logic [ADDR_W-1:0] OFF_PULSE_FIRST    = 8'hc0;
   localparam logic [ADDR_W-1:0] OFF_PULSE_LAST     = 8'hfc;

   // ====================================================================
   // register widths and reset values
   localparam int TC_W = 5;
   localparam int NM_W = 6;
   localparam int IS_W = 4;
   localparam logic [TC_W-1:0] TC_RESET = 5'h00;
   localparam logic [NM_W-1:0] NM_RESET = 6'h00;
   localparam logic [IS_W-1:0] IS_RESET = 4'h0;

   // ====================================================================
   // test_control fields
   localparam int TC_TEST_MODE_ON  = 0;
   localparam int TC_GATE_SELECT   = 1;
   localparam int TC_REG_STROBE    = 2;
   localparam int TC_SOFT_RESET    = 3;
   localparam int TC_INPUT_SOURCE  = 4;

   // counter_nibble_mode fields, also the counter index
   localparam int NM_DATA_TIMER    = 0;
   localparam int NM_BAUD          = 1;
   localparam int NM_VALUE         = 2;
   localparam int NM_RX_TIMEOUT    = 3;
   localparam int NM_ACTIVATION    = 4;
   localparam int NM_CARD_CLOCK    = 5;

   // input_stimulus fields
   localparam int IS_CARD_CLOCK    = 0;
   localparam int IS_CARD_DATA     = 1;
   localparam int IS_CARD_DETECT   = 2;
   localparam int IS_DEACT_REQ     = 3;

   localparam logic [DATA_W-1:0] READ_ZERO = 32'h0000_0000;
   localparam logic [CNT_W-1:0]  CNT_ZERO  = 16'h0000;
   localparam logic [CNT_W-1:0]  CNT_ONE   = 16'h0001;
   localparam logic [NIB_W-1:0]  NIB_ONE   = 4'h1;

   // ====================================================================
   // carrier types
   typedef struct packed {
      logic              sel;
      logic              enable;
      logic              write;
      logic [ADDR_W-1:0] addr;
      logic [DATA_W-1:0] wdata;
   } sct_apb_req_t;

   typedef struct packed {
      logic deactivation_request_in;
      logic card_detect_in;
      logic card_data_in;
      logic card_clock_in;
   } sct_pins_t;

   typedef logic [NUM_CNT-1:0][CNT_W-1:0] sct_cnt_bank_t;

endpackage

// ==== sct_test_ctrl.sv ====
// file: test-mode control of the card interface: registers, clock enable, input mux
//
// Notes on behaviour
// - register-strobe bit 0: every bus access to the block gives a test clock enable.
// - strobe mode clock enable equals enable ANDed with select.
// - register-strobe bit 1: only accesses to the pulse location give an enable.
// - register-strobe bit matters only when test mode and gate select are both set.
// - gate select 0 keeps the internal clock enable high all the time.
// - gate select 1 enables internal clocks for one clock per qualifying access.
// - gate select matters only when test mode is on.
// - test control bit 0 picks normal operation (0) or test mode (1).
// - bus reset clears test mode, gate select and register-strobe bits.
// - nibble-mode counters step all four nibbles together, 0000 to ffff.
// - the nibble mode register reads zero after reset.
// - each nibble mode bit places one of six counters in nibble mode while test mode is on.
// - stimulus register holds readable, writable values for the four primary inputs.
// - input source select picks pads (0) or stimulus bits in test mode (1).
// - test soft reset resets the functional logic but not the test registers.
// - pulse location 0xc0-0xfc reads zero; writes only make the clock enable.
`timescale 1ns/1ps
`default_nettype none

module sct_test_ctrl
(
   input  wire logic                        clk,          // 125 MHz clock
   input  wire logic                        rst,          // bus reset, async, active high
   input  wire logic                        ce,           // freezes all state while low
   input  wire sct_pkg::sct_apb_req_t       apb_req,      // apb request fields
   output logic      [sct_pkg::DATA_W-1:0]  prdata_q,     // apb read data
   input  wire sct_pkg::sct_pins_t          pad_in,       // primary inputs from pads
   input  wire logic [sct_pkg::NUM_CNT-1:0] cnt_step,     // count requests of the core
   output sct_pkg::sct_pins_t               core_in_q,    // primary inputs seen by the core
   output logic                             clk_en_q,     // internal clock enable
   output logic                             func_rst_q,   // functional reset request
   output sct_pkg::sct_cnt_bank_t           cnt_value_q   // six counter values
);

   // ====================================================================
   // local signals
   logic [sct_pkg::TC_W-1:0] test_control_q;
   logic [sct_pkg::NM_W-1:0] counter_nibble_mode_q;
   logic [sct_pkg::IS_W-1:0] input_stimulus_q;
   logic                     setup_phase;
   logic                     wr_setup;
   logic                     test_mode_on;
   logic                     test_clock_gate_select;
   logic                     registered_strobe_select;
   logic                     input_source_select;
   logic                     test_soft_reset;
   logic                     qualifies;
   logic                     clk_en_d;
   logic [sct_pkg::DATA_W-1:0] prdata_d;
   logic [sct_pkg::NM_W-1:0] nibble_eff;
   logic                     cnt_clear;
   sct_pkg::sct_pins_t       stim_pins;
   sct_pkg::sct_pins_t       core_in_d;

   // ====================================================================
   // address decode helpers
   function automatic logic hits(input logic [sct_pkg::ADDR_W-1:0] addr,
                                 input logic [sct_pkg::ADDR_W-1:0] off);
      hits = (addr == off);
   endfunction

   function automatic logic in_pulse_loc(input logic [sct_pkg::ADDR_W-1:0] addr);
      in_pulse_loc = (addr >= sct_pkg::OFF_PULSE_FIRST) &&
                     (addr <= sct_pkg::OFF_PULSE_LAST);
   endfunction

   // ====================================================================
   // bus phase
   // decoding is done in the setup cycle so that every output is a flop and
   // still lines up with the access cycle
   assign setup_phase = apb_req.sel & ~apb_req.enable;
   assign wr_setup    = setup_phase & apb_req.write;

   // ====================================================================
   // mode decode
   assign test_mode_on             = test_control_q[sct_pkg::TC_TEST_MODE_ON];
   assign test_clock_gate_select   = test_mode_on &
                                     test_control_q[sct_pkg::TC_GATE_SELECT];
   assign registered_strobe_select = test_clock_gate_select &
                                     test_control_q[sct_pkg::TC_REG_STROBE];
   assign input_source_select      = test_mode_on &
                                     test_control_q[sct_pkg::TC_INPUT_SOURCE];
   assign test_soft_reset          = test_mode_on &
                                     test_control_q[sct_pkg::TC_SOFT_RESET];

   // ====================================================================
   // test control register
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         test_control_q <= sct_pkg::TC_RESET;
      end
      else if (ce && wr_setup && hits(apb_req.addr, sct_pkg::OFF_TEST_CONTROL))
      begin
         test_control_q <= apb_req.wdata[sct_pkg::TC_W-1:0];
      end
   end

   // ====================================================================
   // counter nibble mode register
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         counter_nibble_mode_q <= sct_pkg::NM_RESET;
      end
      else if (ce && wr_setup && hits(apb_req.addr, sct_pkg::OFF_NIBBLE_MODE))
      begin
         counter_nibble_mode_q <= apb_req.wdata[sct_pkg::NM_W-1:0];
      end
   end

   // ====================================================================
   // input stimulus register
   // the soft reset leaves all three test registers alone so a test can
   // reset the core and keep its setup
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         input_stimulus_q <= sct_pkg::IS_RESET;
      end
      else if (ce && wr_setup && hits(apb_req.addr, sct_pkg::OFF_INPUT_STIMULUS))
      begin
         input_stimulus_q <= apb_req.wdata[sct_pkg::IS_W-1:0];
      end
   end

   // ====================================================================
   // read data
   always_comb
   begin
      prdata_d = sct_pkg::READ_ZERO;
      if (hits(apb_req.addr, sct_pkg::OFF_TEST_CONTROL))
      begin
         prdata_d[sct_pkg::TC_W-1:0] = test_control_q;
      end
      else if (hits(apb_req.addr, sct_pkg::OFF_NIBBLE_MODE))
      begin
         prdata_d[sct_pkg::NM_W-1:0] = counter_nibble_mode_q;
      end
      else if (hits(apb_req.addr, sct_pkg::OFF_INPUT_STIMULUS))
      begin
         prdata_d[sct_pkg::IS_W-1:0] = input_stimulus_q;
      end
      else if (in_pulse_loc(apb_req.addr))
      begin
         prdata_d = sct_pkg::READ_ZERO;
      end
   end

   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         prdata_q <= sct_pkg::READ_ZERO;
      end
      else if (ce && setup_phase && !apb_req.write)
      begin
         prdata_q <= prdata_d;
      end
   end

   // ====================================================================
   // internal clock enable
   // the flop set in the setup cycle is high exactly in the access cycle,
   // which is the cycle where enable and select are both high
   always_comb
   begin
      if (registered_strobe_select)
      begin
         qualifies = in_pulse_loc(apb_req.addr);
      end
      else
      begin
         qualifies = 1'b1;
      end
   end

   always_comb
   begin
      if (!test_clock_gate_select)
      begin
         clk_en_d = 1'b1;
      end
      else
      begin
         clk_en_d = setup_phase & qualifies;
      end
   end

   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         clk_en_q <= 1'b1;
      end
      else if (ce)
      begin
         clk_en_q <= clk_en_d;
      end
   end

   // ====================================================================
   // functional reset
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         func_rst_q <= 1'b1;
      end
      else if (ce)
      begin
         func_rst_q <= test_soft_reset;
      end
   end

   // ====================================================================
   // primary input source
   // the mux is registered; the core sees pad changes one cycle late
   always_comb
   begin
      stim_pins.deactivation_request_in = input_stimulus_q[sct_pkg::IS_DEACT_REQ];
      stim_pins.card_detect_in          = input_stimulus_q[sct_pkg::IS_CARD_DETECT];
      stim_pins.card_data_in            = input_stimulus_q[sct_pkg::IS_CARD_DATA];
      stim_pins.card_clock_in           = input_stimulus_q[sct_pkg::IS_CARD_CLOCK];
      core_in_d = input_source_select ? stim_pins : pad_in;
   end

   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         core_in_q <= '0;
      end
      else if (ce)
      begin
         core_in_q <= core_in_d;
      end
   end

   // ====================================================================
   // counters
   // a count only advances in a cycle the internal clock enable admits
   assign nibble_eff = test_mode_on ? counter_nibble_mode_q : sct_pkg::NM_RESET;
   assign cnt_clear  = test_soft_reset;

   genvar c;
   generate
      for (c = 0; c < sct_pkg::NUM_CNT; c++)
      begin : g_cnt
         sct_nibble_counter u_cnt
         (
            .clk     (clk),
            .rst     (rst),
            .ce      (ce),
            .step    (cnt_step[c] & clk_en_q),
            .clear   (cnt_clear),
            .nibble  (nibble_eff[c]),
            .count_q (cnt_value_q[c])
         );
      end
   endgenerate

endmodule // sct_test_ctrl

`default_nettype wire

// ==== sct_test_ctrl_bench.sv ====
// testbench: register sequences against the card interface test control
`timescale 1ns/1ps
`default_nettype none

module sct_test_ctrl_bench;
   logic                          clk = 1'b0;
   logic                          rst;
   logic                          ce;
   sct_pkg::sct_apb_req_t         apb_req;
   logic [sct_pkg::DATA_W-1:0]    prdata_q;
   sct_pkg::sct_pins_t            pad_in;
   logic [sct_pkg::NUM_CNT-1:0]   cnt_step;
   sct_pkg::sct_pins_t            core_in_q;
   logic                          clk_en_q;
   logic                          func_rst_q;
   sct_pkg::sct_cnt_bank_t        cnt_value_q;
   int                            fail_count = 0;
   int                            check_count = 0;
   int                            cycles = 0;
   int                            pulse_tot = 0;
   logic [31:0]                   d;
   logic [5:0]                    pat [2] = '{6'h15, 6'h2a};
   logic [7:0]                    offs [3] = '{8'h80, 8'h84, 8'h88};

   always #4 clk = ~clk;

   sct_apb_master u_mst (.clk(clk), .prdata_q(prdata_q), .apb_req(apb_req));

   sct_test_ctrl DUT (.clk(clk), .rst(rst), .ce(ce), .apb_req(apb_req), .prdata_q(prdata_q),
      .pad_in(pad_in), .cnt_step(cnt_step), .core_in_q(core_in_q), .clk_en_q(clk_en_q),
      .func_rst_q(func_rst_q), .cnt_value_q(cnt_value_q));

   // ====================================================================
   // helpers
   task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
      check_count++;
      if (seen !== exp)
      begin
         fail_count++;
         $display("BAD %s expected %h seen %h", name, exp, seen);
      end
   endtask

   task automatic idle(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask

   // counts enable pulses over one access; strobe edges land in the access cycle
   // the running total has one writer; the task only takes differences
   task automatic count_acc(input logic w, input logic [7:0] a, input int exp);
      int base;
      idle(1);
      base = pulse_tot;
      u_mst.xfer(w, a, 32'h0000_0000, d);
      idle(1);
      check("pulse count", 32'(pulse_tot - base), 32'(exp));
   endtask

   task automatic results();
      $display("checks %0d mismatches %0d", check_count, fail_count);
      if (fail_count == 0 && check_count > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask

   always @(posedge clk)
   begin
      pulse_tot <= pulse_tot + int'(clk_en_q);
      cycles <= cycles + 1;
      if (cycles == 3000)
      begin
         fail_count++;
         results();
      end
   end

   // ====================================================================
   // sequence
   initial
   begin
      rst = 1'b1;
      ce = 1'b1;
      pad_in = sct_pkg::sct_pins_t'(4'h0);
      cnt_step = 6'h00;
      repeat (8) @(posedge clk);
      rst <= 1'b0;
      for (int i = 0; i < 3; i++)
      begin
         u_mst.rd(offs[i], d);
         check("reset value", d, 32'h0000_0000);
      end
      $display("test reset done");

      u_mst.wr(sct_pkg::OFF_NIBBLE_MODE, 32'hffff_ffff);
      u_mst.rd(sct_pkg::OFF_NIBBLE_MODE, d);
      check("nibble mode", d, 32'h0000_003f);
      u_mst.wr(sct_pkg::OFF_INPUT_STIMULUS, 32'hffff_fff5);
      u_mst.rd(sct_pkg::OFF_INPUT_STIMULUS, d);
      check("stimulus", d, 32'h0000_0005);
      u_mst.wr(8'hc4, 32'hffff_ffff);
      u_mst.rd(8'hc4, d);
      check("pulse location", d, 32'h0000_0000);
      @(posedge clk);
      ce <= 1'b0;
      u_mst.wr(sct_pkg::OFF_NIBBLE_MODE, 32'h0000_0000);
      ce <= 1'b1;
      u_mst.rd(sct_pkg::OFF_NIBBLE_MODE, d);
      check("frozen write", d, 32'h0000_003f);
      $display("test registers done");

      pad_in <= sct_pkg::sct_pins_t'(4'ha);
      u_mst.wr(sct_pkg::OFF_TEST_CONTROL, 32'h0000_0010);
      idle(2);
      check("pads outside test", 32'(core_in_q), 32'h0000_000a);
      u_mst.wr(sct_pkg::OFF_TEST_CONTROL, 32'h0000_0011);
      idle(2);
      check("stimulus in test", 32'(core_in_q), 32'h0000_0005);
      $display("test input mux done");

      for (int p = 0; p < 2; p++)
      begin
         u_mst.wr(sct_pkg::OFF_TEST_CONTROL, 32'h0000_0009);
         idle(2);
         check("soft reset", 32'(func_rst_q), 32'h0000_0001);
         u_mst.rd(sct_pkg::OFF_TEST_CONTROL, d);
         check("control kept", d, 32'h0000_0009);
         u_mst.wr(sct_pkg::OFF_TEST_CONTROL, 32'h0000_0001);
         u_mst.wr(sct_pkg::OFF_NIBBLE_MODE, 32'(pat[p]));
         @(posedge clk);
         cnt_step <= 6'h3f;
         repeat (2) @(posedge clk);
         cnt_step <= 6'h00;
         idle(2);
         for (int c = 0; c < 6; c++)
            check("counter", 32'(cnt_value_q[c]), pat[p][c] ? 32'h2222 : 32'h0002);
      end
      $display("test nibble done");

      u_mst.wr(sct_pkg::OFF_TEST_CONTROL, 32'h0000_0003);
      count_acc(1'b0, sct_pkg::OFF_NIBBLE_MODE, 1);
      u_mst.wr(sct_pkg::OFF_TEST_CONTROL, 32'h0000_0007);
      count_acc(1'b0, sct_pkg::OFF_NIBBLE_MODE, 0);
      count_acc(1'b1, sct_pkg::OFF_PULSE_FIRST, 1);
      count_acc(1'b0, sct_pkg::OFF_PULSE_LAST, 1);
      for (int v = 0; v < 2; v++)
      begin
         u_mst.wr(sct_pkg::OFF_TEST_CONTROL, v == 0 ? 32'h0000_0005 : 32'h0000_0002);
         idle(3);
         check("enable held high", 32'(clk_en_q), 32'h0000_0001);
      end
      $display("test clock enable done");
      results();
   end
endmodule // sct_test_ctrl_bench

`default_nettype wire

// ==== sct_test_ctrl_properties.sv ====
// checker: port-level properties of the card interface test control
`timescale 1ns/1ps
`default_nettype none

module sct_test_ctrl_props
(
   input wire logic                       clk,        // clock
   input wire logic                       rst,        // bus reset
   input wire logic                       ce,         // global clock enable
   input wire sct_pkg::sct_apb_req_t      apb_req,    // apb request fields
   input wire logic [sct_pkg::DATA_W-1:0] prdata_q,   // read data
   input wire sct_pkg::sct_pins_t         pad_in,     // pad inputs
   input wire sct_pkg::sct_pins_t         core_in_q,  // inputs seen by core
   input wire logic                       clk_en_q,   // internal clock enable
   input wire logic                       func_rst_q  // functional reset
);
   // ====================================================================
   // shadow of the written test control and input stimulus registers
   logic [4:0] tc_q;
   logic [3:0] is_q;
   logic       up_q;
   logic       setup;
   logic       pulse_at;
   logic       mapped;
   logic       gated;
   logic       stim_sel;
   logic       soft_on;
   assign setup    = apb_req.sel && !apb_req.enable && ce;
   assign pulse_at = apb_req.addr >= sct_pkg::OFF_PULSE_FIRST
                     && apb_req.addr <= sct_pkg::OFF_PULSE_LAST;
   assign mapped   = apb_req.addr == sct_pkg::OFF_TEST_CONTROL
                     || apb_req.addr == sct_pkg::OFF_NIBBLE_MODE
                     || apb_req.addr == sct_pkg::OFF_INPUT_STIMULUS;
   assign gated    = tc_q[0] && tc_q[1];
   assign stim_sel = tc_q[0] && tc_q[4];
   assign soft_on  = tc_q[0] && tc_q[3];

   // up_q masks the first edge, where $past still sees reset values
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst) up_q <= 1'b0;
      else up_q <= 1'b1;
   end

   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         tc_q <= 5'h00;
         is_q <= 4'h0;
      end
      else if (setup && apb_req.write)
      begin
         if (apb_req.addr == sct_pkg::OFF_TEST_CONTROL) tc_q <= apb_req.wdata[4:0];
         if (apb_req.addr == sct_pkg::OFF_INPUT_STIMULUS) is_q <= apb_req.wdata[3:0];
      end
   end

   // ====================================================================
   // properties
   gate_off_high_a: assert property (@(posedge clk) disable iff (rst)
      up_q && !$past(gated) |-> clk_en_q) else $error("clock enable low while not gated");
   strobe_pulse_a: assert property (@(posedge clk) disable iff (rst)
      gated && !tc_q[2] && setup |=> clk_en_q) else $error("no strobe pulse");
   reg_pulse_a: assert property (@(posedge clk) disable iff (rst)
      gated && tc_q[2] && setup && pulse_at |=> clk_en_q) else $error("no pulse location pulse");
   no_pulse_a: assert property (@(posedge clk) disable iff (rst)
      gated && !(setup && (!tc_q[2] || pulse_at)) |=> !clk_en_q) else $error("spurious pulse");
   read_zero_a: assert property (@(posedge clk) disable iff (rst)
      setup && !apb_req.write && !mapped |=> prdata_q == sct_pkg::READ_ZERO)
      else $error("unmapped read not zero");
   stim_path_a: assert property (@(posedge clk) disable iff (rst)
      up_q && $past(stim_sel) |-> core_in_q == $past(is_q))
      else $error("core inputs not from stimulus");
   pad_path_a: assert property (@(posedge clk) disable iff (rst)
      up_q && !$past(stim_sel) |-> core_in_q == $past(pad_in))
      else $error("core inputs not from pads");
   soft_reset_a: assert property (@(posedge clk) disable iff (rst)
      up_q |-> func_rst_q == $past(soft_on)) else $error("soft reset wrong");
endmodule // sct_test_ctrl_props

bind sct_test_ctrl sct_test_ctrl_props u_props (.clk(clk), .rst(rst), .ce(ce),
   .apb_req(apb_req), .prdata_q(prdata_q), .pad_in(pad_in), .core_in_q(core_in_q),
   .clk_en_q(clk_en_q), .func_rst_q(func_rst_q));

`default_nettype wire
